/* src/gdnap_pkg.sv */
// package for the non-adaptive gate drive phase control block
package gdnap_pkg;
    // gate control mode encodings
    localparam logic [1:0] MODE_NO_PRE    = 2'h0;
    localparam logic [1:0] MODE_FIXED_PRE = 2'h1;
    localparam logic [1:0] MODE_ADAPT_1   = 2'h2;
    localparam logic [1:0] MODE_ADAPT_2   = 2'h3;
    // current code layout
    localparam int         CODE_W         = 6;
    localparam int         CODE_STEPS     = 64;
    localparam logic [5:0] CODE_MIN       = 6'h00;
    localparam logic [5:0] CODE_MAX       = 6'h3F;
    // reset values and delay width
    localparam logic [1:0] MODE_RST       = 2'h0;
    localparam logic [5:0] CODE_RST       = 6'h00;
    localparam logic [7:0] DELAY_RST      = 8'h00;
    localparam int         DELAY_W        = 8;
    // phase timer reset value
    localparam logic [7:0] TIMER_RST      = 8'h00;
    // phase states
    typedef enum logic [2:0] {
        GDNAP_IDLE, GDNAP_PRECHG, GDNAP_CHG, GDNAP_ON,
        GDNAP_PREDIS, GDNAP_DIS, GDNAP_OFF
    } gdnap_phase_t;
endpackage : gdnap_pkg

/* src/gdnap_top.sv */
// phase sequencer and current code selection for one pwm gate driver
`timescale 1ns/100ps
`default_nettype none
module gdnap_top #(
    parameter int DELAY_W = gdnap_pkg::DELAY_W
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // configuration
    input  wire logic [1:0]         gate_control_mode,
    input  wire logic [5:0]         charge_current_code,
    input  wire logic [5:0]         discharge_current_code,
    input  wire logic [5:0]         precharge_init_code,
    input  wire logic [5:0]         predischarge_init_code,
    input  wire logic [5:0]         adaptive_precharge_code,
    input  wire logic [5:0]         adaptive_predischarge_code,
    input  wire logic [7:0]         precharge_phase_time,
    input  wire logic [7:0]         predischarge_phase_time,
    input  wire logic [DELAY_W-1:0] target_delay_config,
    // pwm and gate feedback
    input  wire logic               pwm_in,
    input  wire logic               gate_on_reached,
    input  wire logic               gate_off_reached,
    // driver outputs
    output logic                    source_en,
    output logic                    sink_en,
    output logic [5:0]              drive_code,
    output logic                    adaptive_active,
    // status
    output logic [DELAY_W-1:0]      effective_delay_on,
    output logic [DELAY_W-1:0]      effective_delay_off
);
    gdnap_pkg::gdnap_phase_t state;
    gdnap_pkg::gdnap_phase_t next_state;
    logic [7:0]              timer;
    logic [7:0]              next_timer;
    logic [DELAY_W-1:0]      meas;
    logic [DELAY_W-1:0]      next_meas;
    logic [DELAY_W-1:0]      next_eff_on;
    logic [DELAY_W-1:0]      next_eff_off;
    logic                    pwm_q;
    logic                    non_adaptive;
    logic                    skip_pre;

    assign non_adaptive    = (gate_control_mode == gdnap_pkg::MODE_NO_PRE) ||
                             (gate_control_mode == gdnap_pkg::MODE_FIXED_PRE);
    assign adaptive_active = !non_adaptive;
    assign skip_pre = (gate_control_mode == gdnap_pkg::MODE_NO_PRE);

    // phase sequence and delay measurement
    always_comb
    begin
        next_state   = state;
        next_timer   = timer;
        next_meas    = meas;
        next_eff_on  = effective_delay_on;
        next_eff_off = effective_delay_off;
        if (meas != {DELAY_W{1'b1}})
            next_meas = meas + 1'b1; // saturates so a stuck gate reads max
        case (state)
            gdnap_pkg::GDNAP_IDLE,
            gdnap_pkg::GDNAP_OFF:
            begin
                if (pwm_in && !pwm_q)
                begin
                    next_meas  = '0;
                    next_timer = gdnap_pkg::TIMER_RST;
                    next_state = skip_pre ? gdnap_pkg::GDNAP_CHG
                                          : gdnap_pkg::GDNAP_PRECHG;
                end
            end
            gdnap_pkg::GDNAP_PRECHG:
            begin
                next_timer = timer + 8'h01;
                if (timer + 8'h01 >= precharge_phase_time)
                    next_state = gdnap_pkg::GDNAP_CHG;
            end
            gdnap_pkg::GDNAP_CHG:
            begin
                if (gate_on_reached)
                begin
                    next_eff_on = meas;
                    next_state  = gdnap_pkg::GDNAP_ON;
                end
            end
            gdnap_pkg::GDNAP_ON:
            begin
                if (!pwm_in && pwm_q)
                begin
                    next_meas  = '0;
                    next_timer = gdnap_pkg::TIMER_RST;
                    next_state = skip_pre ? gdnap_pkg::GDNAP_DIS
                                          : gdnap_pkg::GDNAP_PREDIS;
                end
            end
            gdnap_pkg::GDNAP_PREDIS:
            begin
                next_timer = timer + 8'h01;
                if (timer + 8'h01 >= predischarge_phase_time)
                    next_state = gdnap_pkg::GDNAP_DIS;
            end
            gdnap_pkg::GDNAP_DIS:
            begin
                if (gate_off_reached)
                begin
                    next_eff_off = meas;
                    next_state   = gdnap_pkg::GDNAP_OFF;
                end
            end
            default:
                next_state = gdnap_pkg::GDNAP_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state               <= gdnap_pkg::GDNAP_IDLE;
            timer               <= gdnap_pkg::TIMER_RST;
            meas                <= DELAY_W'(gdnap_pkg::DELAY_RST);
            effective_delay_on  <= DELAY_W'(gdnap_pkg::DELAY_RST);
            effective_delay_off <= DELAY_W'(gdnap_pkg::DELAY_RST);
            pwm_q               <= 1'b0;
        end
        else
        begin
            state               <= next_state;
            timer               <= next_timer;
            meas                <= next_meas;
            effective_delay_on  <= next_eff_on;
            effective_delay_off <= next_eff_off;
            pwm_q               <= pwm_in;
        end
    end

    // current code per phase; target delay is not used to steer codes
    always_comb
    begin
        source_en  = 1'b0;
        sink_en    = 1'b0;
        drive_code = gdnap_pkg::CODE_MIN;
        case (state)
            gdnap_pkg::GDNAP_PRECHG:
            begin
                source_en = 1'b1;
                drive_code = non_adaptive ? precharge_init_code
                                          : adaptive_precharge_code;
            end
            gdnap_pkg::GDNAP_CHG:
            begin
                source_en = 1'b1;
                drive_code = charge_current_code;
            end
            gdnap_pkg::GDNAP_PREDIS:
            begin
                sink_en = 1'b1;
                drive_code = non_adaptive ? predischarge_init_code
                                          : adaptive_predischarge_code;
            end
            gdnap_pkg::GDNAP_DIS:
            begin
                sink_en = 1'b1;
                drive_code = discharge_current_code;
            end
            default:
                drive_code = gdnap_pkg::CODE_MIN; // code 0 is 0.5 mA
        endcase
    end
    // combinational pick above; target unused in this block
    logic unused_target;
    assign unused_target = ^target_delay_config;

    // assertions, all in the core clock domain
    default clocking assert_clk @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // mode may change mid-phase, so only the entry into precharge is judged
    a_skip_pre_none: assert property (
        skip_pre && state != gdnap_pkg::GDNAP_PRECHG
        |=> state != gdnap_pkg::GDNAP_PRECHG)
        else $error("precharge entered in mode 00");
    a_skip_predis: assert property (
        skip_pre && state == gdnap_pkg::GDNAP_ON && !pwm_in && pwm_q
        |=> state == gdnap_pkg::GDNAP_DIS)
        else $error("predischarge not skipped");
    a_prechg_code: assert property (
        state == gdnap_pkg::GDNAP_PRECHG && non_adaptive
        |-> drive_code == precharge_init_code && source_en)
        else $error("wrong precharge code");
    a_predis_code: assert property (
        state == gdnap_pkg::GDNAP_PREDIS && non_adaptive
        |-> drive_code == predischarge_init_code && sink_en)
        else $error("wrong predischarge code");
    a_mode_flag: assert property (
        gate_control_mode[1] == adaptive_active)
        else $error("adaptive flag wrong");
    a_on_capture: assert property (
        state == gdnap_pkg::GDNAP_CHG && gate_on_reached
        |=> effective_delay_on == $past(meas))
        else $error("on delay not captured");
    a_off_capture: assert property (
        state == gdnap_pkg::GDNAP_DIS && gate_off_reached
        |=> effective_delay_off == $past(meas))
        else $error("off delay not captured");
    a_chg_code: assert property (
        state == gdnap_pkg::GDNAP_CHG
        |-> drive_code == charge_current_code && !sink_en)
        else $error("wrong charge code");
    a_dis_code: assert property (
        state == gdnap_pkg::GDNAP_DIS
        |-> drive_code == discharge_current_code && !source_en)
        else $error("wrong discharge code");
    a_no_overlap: assert property (
        !(source_en && sink_en))
        else $error("source and sink both on");
    // main scenarios
    c_prechg: cover property (
        state == gdnap_pkg::GDNAP_PRECHG ##1 state == gdnap_pkg::GDNAP_CHG);
    c_skip: cover property (
        skip_pre && state == gdnap_pkg::GDNAP_CHG);
    c_full: cover property (
        state == gdnap_pkg::GDNAP_DIS ##1 state == gdnap_pkg::GDNAP_OFF);
endmodule : gdnap_top
`default_nettype wire

/* verification/gdnap_gate_model.sv */
// behavioural external mosfet gate, charged and drained by the driver
`timescale 1ns/100ps
`default_nettype none
module gdnap_gate_model #(
    parameter int THR = 12
) (
    // clock
    input  wire logic core_clk,
    // drive from the block
    input  wire logic source_en,
    input  wire logic sink_en,
    // threshold feedback
    output logic      gate_on_reached,
    output logic      gate_off_reached
);
    int lvl = 0;
    // one step a cycle, clamped at the rails like a real gate
    always @(posedge core_clk)
    begin
        if (source_en && lvl < THR)
            lvl <= lvl + 1;
        else if (sink_en && lvl > 0)
            lvl <= lvl - 1;
    end
    // thresholds above every pre-phase, so a pre-phase never ends a switch
    assign gate_on_reached  = (lvl >= THR);
    assign gate_off_reached = (lvl == 0);
endmodule : gdnap_gate_model
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the non-adaptive gate drive phase control
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic core_clk = 1'b0, rst_n = 1'b0, pwm_in = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [5:0] chg = 6'h00, dis = 6'h00, pc = 6'h00, pd = 6'h00;
    logic [5:0] apc = 6'h00, apd = 6'h00;
    logic [7:0] tpc = 8'h00, tpd = 8'h00, tgt = 8'h00;
    logic       on_r, off_r, src, snk, adapt;
    logic [5:0] code;
    logic [7:0] d_on, d_off;
    int n_errors = 0, n_compared = 0, n_src = 0, n_snk = 0;
    gdnap_top dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .gate_control_mode(mode), .charge_current_code(chg),
        .discharge_current_code(dis), .precharge_init_code(pc),
        .predischarge_init_code(pd), .adaptive_precharge_code(apc),
        .adaptive_predischarge_code(apd), .precharge_phase_time(tpc),
        .predischarge_phase_time(tpd), .target_delay_config(tgt),
        .pwm_in(pwm_in), .gate_on_reached(on_r), .gate_off_reached(off_r),
        .source_en(src), .sink_en(snk), .drive_code(code),
        .adaptive_active(adapt), .effective_delay_on(d_on),
        .effective_delay_off(d_off));
    gdnap_gate_model gate_u (.core_clk(core_clk), .source_en(src),
        .sink_en(snk), .gate_on_reached(on_r), .gate_off_reached(off_r));
    initial forever #2.5 core_clk = ~core_clk;
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // pre-phase length the model expects: none in mode 00, else max(1,t)
    function automatic int plen(logic [7:0] t);
        return (mode == gdnap_pkg::MODE_NO_PRE) ? 0 : ((t < 2) ? 1 : t);
    endfunction : plen
    // reference model, judged once per cycle where outputs have settled
    always @(negedge core_clk)
    begin
        if (rst_n)
        begin
            check("adaptive_active", {7'h00, adapt}, {7'h00, mode[1]});
            check("overlap", {7'h00, src & snk}, 8'h00);
            if (src)
                check("src_code", code,
                      (n_src < plen(tpc)) ? (mode[1] ? apc : pc) : chg);
            else if (snk)
                check("snk_code", code,
                      (n_snk < plen(tpd)) ? (mode[1] ? apd : pd) : dis);
            else
                check("idle_code", code, 8'h00);
            if (!src && n_src > 0)
                check("delay_on", d_on, 8'(n_src - 1));
            if (!snk && n_snk > 0)
                check("delay_off", d_off, 8'(n_snk - 1));
            n_src = src ? n_src + 1 : 0;
            n_snk = snk ? n_snk + 1 : 0;
        end
    end
    // bounded wait for a switch to finish, turn-on when on is set
    task automatic wait_for(bit on);
        bit done;
        done = 1'b0;
        repeat (80)
        begin
            @(posedge core_clk);
            done = on ? (on_r && !src) : (off_r && !snk);
            if (done)
                break;
        end
        check("switch_done", {7'h00, done}, 8'h01);
    endtask : wait_for
    initial
    begin
        #200000;
        n_errors++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'hb0d3));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        // every mode six times; first rounds hit the code extremes
        for (int i = 0; i < 24; i++)
        begin
            @(posedge core_clk);
            mode <= 2'(i);
            pc  <= (i < 4) ? (i[1] ? gdnap_pkg::CODE_MAX : gdnap_pkg::CODE_MIN)
                           : 6'($urandom);
            pd  <= (i < 4) ? (i[0] ? gdnap_pkg::CODE_MAX : gdnap_pkg::CODE_MIN)
                           : 6'($urandom);
            chg <= ~pc;
            dis <= ~pd;
            apc <= 6'($urandom);
            apd <= 6'($urandom);
            tpc <= 8'($urandom_range(0, 7));
            tpd <= 8'($urandom_range(0, 7));
            tgt <= 8'($urandom);
            @(posedge core_clk);
            pwm_in <= 1'b1;
            wait_for(1'b1);
            repeat ($urandom_range(0, 3)) @(posedge core_clk);
            pwm_in <= 1'b0;
            wait_for(1'b0);
        end
        repeat (3) @(posedge core_clk);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
